// >>> bench/mem_model.sv
`timescale 1ns/100ps
module mem_model (
  input  logic        clk,
  input  logic        rst_n,
  input  logic        rd,
  input  logic [31:0] addr,
  output logic        ack,
  output logic [31:0] data
);
  logic [31:0] tbl [logic [31:0]];
  logic [1:0]  wait_ff;
  int          reads = 0;

  task automatic put(input logic [31:0] a, input logic [31:0] d);
    tbl[a] = d;
  endtask

  // Random 0..2 cycle latency; data toggles outside the acknowledge cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack     <= 1'b0;
      data    <= 32'h0;
      wait_ff <= 2'h0;
    end else if (ack) begin
      ack  <= 1'b0;
      data <= ~data;
    end else if (rd && wait_ff == 2'h0) begin
      ack     <= 1'b1;
      data    <= tbl.exists(addr) ? tbl[addr] : 32'h0;
      wait_ff <= 2'($urandom_range(2));
      reads   <= reads + 1;
    end else begin
      data <= ~data;
      if (rd) wait_ff <= wait_ff - 2'h1;
    end
  end
endmodule // mem_model

// >>> bench/mmu_tlb_table_walk_test.sv
`timescale 1ns/100ps
module mmu_tlb_table_walk_test;
  import mmu_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  logic        wr = 1'b0;
  logic        ifetch = 1'b0;
  logic        priv = 1'b1;
  logic        rwr = 1'b0;
  logic        rrd = 1'b0;
  logic        rd_d = 1'b0;
  logic [31:0] va = 32'h0;
  logic [31:0] rwd = 32'h0;
  logic [31:0] v;
  logic [3:0]  ra = 4'h0;
  wire         done, abort, mrd, mack;
  wire  [31:0] pa, maddr, mdata, rdata;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n0;
  logic [32:0] core_q [$];
  logic [31:0] reg_q [$];

  always #5 clk = ~clk;

  mmu_top mmu_top_inst (.SYS_CLK(clk), .RST_N(rst_n), .REQ(req), .VA(va), .WRITE(wr), .PRIV(priv),
    .IFETCH(ifetch), .DONE(done), .ABORT(abort), .PA(pa), .MEM_RD(mrd), .MEM_ADDR(maddr),
    .MEM_ACK(mack), .MEM_DATA(mdata), .REG_ADDR(ra), .REG_WDATA(rwd), .REG_WR(rwr), .REG_RD(rrd),
    .REG_RDATA(rdata));
  mem_model mem_model_inst (.clk(clk), .rst_n(rst_n), .rd(mrd), .addr(maddr), .ack(mack), .data(mdata));

  task automatic tally_and_finish();
    $display("TB: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_core(input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    chk_core({1'b0, e}, {1'b0, g});
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra  <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    ra  <= a;
    rrd <= 1'b1;
    reg_q.push_back(e);
    @(posedge clk);
    rrd <= 1'b0;
  endtask

  task automatic acc(input logic [31:0] a, input logic w, input logic f, input logic ab, input logic [31:0] p);
    int i;
    @(posedge clk);
    va     <= a;
    wr     <= w;
    ifetch <= f;
    req    <= 1'b1;
    core_q.push_back({ab, p});
    @(posedge clk);
    req <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (i == 200) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Results are matched in order against what the drivers noted
  always @(posedge clk) begin
    rd_d <= rrd;
    if (done === 1'b1) begin
      if (core_q.size() == 0) n_mismatch++;
      else chk_core(core_q.pop_front(), {abort, pa});
    end
    if (rd_d === 1'b1) begin
      if (reg_q.size() == 0) n_mismatch++;
      else chk_reg(reg_q.pop_front(), rdata);
    end
  end

  initial begin
    void'($urandom(63));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      acc(v, v[0], v[1], 1'b0, v);
    end
    rreg(4'hf, 32'h0);
    mem_model_inst.put(32'h0010048c, 32'habc00c22);
    mem_model_inst.put(32'h00100800, 32'h00200441);
    mem_model_inst.put(32'h00100804, 32'h00200441);
    mem_model_inst.put(32'h0020040c, 32'h55555002);
    mem_model_inst.put(32'h00100c00, 32'h00200821);
    for (int k = 0; k < 16; k++) mem_model_inst.put(32'h00200900 + 32'(k * 4), 32'h777700c1);
    mem_model_inst.put(32'h00101400, 32'h00000003);
    mem_model_inst.put(32'h00101800, 32'h60000c62);
    mem_model_inst.put(32'h00101c00, 32'h80000822);
    wreg(REG_TBASE, 32'h00100000);
    wreg(REG_DOMAIN, 32'h00000034);
    wreg(REG_CTRL, 32'h00000001);
    rreg(REG_TBASE, 32'h00100000);
    rreg(REG_DOMAIN, 32'h00000034);
    rreg(REG_CTRL, 32'h00000001);
    n0 = mem_model_inst.reads;
    acc(32'h12345678, 1'b0, 1'b0, 1'b0, 32'habc45678);
    acc(32'h12345678, 1'b1, 1'b0, 1'b0, 32'habc45678);
    chk_reg(32'(n0 + 1), 32'(mem_model_inst.reads));
    acc(32'h20003456, 1'b1, 1'b0, 1'b0, 32'h55555456);
    acc(32'h30045678, 1'b0, 1'b0, 1'b0, 32'h77775678);
    chk_reg(32'(n0 + 5), 32'(mem_model_inst.reads));
    acc(32'h30048678, 1'b0, 1'b0, 1'b1, 32'h0);
    rreg(REG_FSTATUS, 32'h0000001f);
    rreg(REG_FADDR, 32'h30048678);
    acc(32'h40000000, 1'b0, 1'b0, 1'b1, 32'h0);
    rreg(REG_FSTATUS, 32'h00000005);
    acc(32'h50000000, 1'b0, 1'b1, 1'b1, 32'h0);
    rreg(REG_FSTATUS, 32'h00000005);
    rreg(REG_FADDR, 32'h40000000);
    acc(32'h60000000, 1'b1, 1'b0, 1'b1, 32'h0);
    rreg(REG_FSTATUS, 32'h00000039);
    acc(32'h20100000, 1'b0, 1'b0, 1'b1, 32'h0);
    rreg(REG_FSTATUS, 32'h00000027);
    priv <= 1'b0;
    acc(32'h70000123, 1'b0, 1'b0, 1'b0, 32'h80000123);
    acc(32'h70000456, 1'b1, 1'b0, 1'b1, 32'h0);
    rreg(REG_FSTATUS, 32'h0000001d);
    priv <= 1'b1;
    acc(32'h70000789, 1'b1, 1'b0, 1'b0, 32'h80000789);
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      acc({12'h123, v[19:0]}, v[20], 1'b0, 1'b0, {12'habc, v[19:0]});
    end
    wreg(REG_FLUSH, 32'h0);
    n0 = mem_model_inst.reads;
    acc(32'h12345000, 1'b0, 1'b0, 1'b0, 32'habc45000);
    acc(32'h30045000, 1'b0, 1'b0, 1'b0, 32'h77775000);
    wreg(REG_FLUSH1, 32'h30045678);
    acc(32'h30045000, 1'b0, 1'b0, 1'b0, 32'h77775000);
    acc(32'h12345000, 1'b0, 1'b0, 1'b0, 32'habc45000);
    chk_reg(32'(n0 + 5), 32'(mem_model_inst.reads));
    wreg(REG_CTRL, 32'h0);
    acc(32'h60000000, 1'b1, 1'b0, 1'b0, 32'h60000000);
    wreg(REG_CTRL, 32'h00000001);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rreg(REG_CTRL, 32'h0);
    acc(32'h12345678, 1'b0, 1'b0, 1'b0, 32'h12345678);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule // mmu_tlb_table_walk_test

// >>> bench/mmu_top_props.sv
`timescale 1ns/100ps
module mmu_props
  import mmu_pkg::*;
(
  input logic        SYS_CLK,
  input logic        RST_N,
  input logic        REQ,
  input logic [31:0] VA,
  input logic        DONE,
  input logic        ABORT,
  input logic [31:0] PA,
  input logic        MEM_RD,
  input logic [31:0] MEM_ADDR,
  input logic        MEM_ACK,
  input logic [31:0] MEM_DATA,
  input logic [3:0]  REG_ADDR,
  input logic [31:0] REG_WDATA,
  input logic        REG_WR
);
  logic        busy_ff;
  logic        en_ff;
  logic [1:0]  nf_ff;
  logic [31:0] va_ff;
  logic [31:0] tb_ff;
  logic [31:0] d_ff;
  wire         take = REQ && (!busy_ff || DONE);
  wire         ack  = MEM_RD && MEM_ACK;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_ff <= 1'b0;
      en_ff   <= 1'b0;
      nf_ff   <= 2'h0;
      va_ff   <= 32'h0;
      tb_ff   <= 32'h0;
      d_ff    <= 32'h0;
    end else begin
      busy_ff <= take || (busy_ff && !DONE);
      nf_ff   <= take ? 2'h0 : nf_ff + 2'(ack);
      if (take) va_ff <= VA;
      if (ack) d_ff <= MEM_DATA;
      if (REG_WR && REG_ADDR == REG_CTRL) en_ff <= REG_WDATA[CTRL_EN_BIT];
      if (REG_WR && REG_ADDR == REG_TBASE) tb_ff <= REG_WDATA;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  pass_thru_a: assert property (take && !en_ff |=> DONE && !ABORT && PA == $past(VA))
    else $error("untranslated access not passed through");
  hit_or_walk_a: assert property (take && en_ff |-> ##2 (DONE != MEM_RD))
    else $error("neither answer nor walk two cycles after request");
  abort_zero_a: assert property (ABORT |-> DONE && PA == 32'h0)
    else $error("abort without answer or with address");
  done_owner_a: assert property (DONE |-> busy_ff)
    else $error("answer without pending request");
  first_addr_a: assert property ($rose(MEM_RD) |-> MEM_ADDR == {tb_ff[31:14], va_ff[31:20], 2'b00})
    else $error("first-level fetch address wrong");
  rd_hold_a: assert property (MEM_RD && !MEM_ACK |=> MEM_RD && $stable(MEM_ADDR))
    else $error("descriptor read dropped before acknowledge");
  second_addr_a: assert property (ack && nf_ff == 2'h0 && MEM_DATA[1:0] == L1_COARSE
    |=> MEM_RD && MEM_ADDR == {d_ff[31:10], va_ff[19:12], 2'b00})
    else $error("second-level fetch address wrong");
  bad_type_a: assert property (ack && (MEM_DATA[1:0] == DESC_FAULT || MEM_DATA[1:0] == 2'h3)
    |=> !MEM_RD ##[0:6] (DONE && ABORT))
    else $error("invalid descriptor not aborted");
  one_fetch_a: assert property (ack && nf_ff == 2'h0 && MEM_DATA[1:0] == L1_SECTION
    |=> !MEM_RD ##[1:6] DONE)
    else $error("section walk not finished after one fetch");

  cover property (take && en_ff);
  cover property (ack && nf_ff == 2'h1);
  cover property (DONE && ABORT);
endmodule // mmu_props

bind mmu_top mmu_props mmu_props_inst (.SYS_CLK, .RST_N, .REQ, .VA, .DONE, .ABORT, .PA, .MEM_RD,
  .MEM_ADDR, .MEM_ACK, .MEM_DATA, .REG_ADDR, .REG_WDATA, .REG_WR);

// >>> hdl/mmu_top.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module mmu_top
  import mmu_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        REQ,
  input  wire logic [31:0] VA,
  input  wire logic        WRITE,
  input  wire logic        PRIV,
  input  wire logic        IFETCH,
  output logic             DONE,
  output logic             ABORT,
  output logic [31:0]      PA,
  output logic             MEM_RD,
  output logic [31:0]      MEM_ADDR,
  input  wire logic        MEM_ACK,
  input  wire logic [31:0] MEM_DATA,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [31:0]      REG_RDATA
);
  typedef enum logic [2:0] {IDLE, LOOK, L1_WAIT, L2_WAIT, FILL} walk_e;

  typedef struct packed {
    walk_e       st;
    logic [31:0] va;
    logic        wr;
    logic        priv;
    logic        ifetch;
    logic [31:0] desc1;
    logic        done;
    logic        abort;
    logic [31:0] pa;
    logic        mem_rd;
    logic [31:0] mem_addr;
    logic [31:0] rdata;
    logic [10:0] ctrl;
    logic [17:0] tbase;
    logic [31:0] domain_ctl;
    logic [3:0]  fs_code;
    logic [3:0]  fs_dom;
    logic [31:0] fault_va;
  } state_s;

  state_s state_ff, nxt_state;

  // Descriptor layouts as fetched from the tables
  typedef struct packed {
    logic [11:0] base;
    logic [7:0]  must_be_zero_field;
    logic [1:0]  perm;
    logic        spare;
    logic [3:0]  domain;
    logic        impl;
    logic [1:0]  cb;
    logic [1:0]  kind;
  } sect_desc_s;

  typedef struct packed {
    logic [21:0] base;
    logic        spare;
    logic [3:0]  domain;
    logic [2:0]  impl;
    logic [1:0]  kind;
  } ptr_desc_s;

  typedef struct packed {
    logic [19:0] base;
    logic [7:0]  perm;
    logic [1:0]  cb;
    logic [1:0]  kind;
  } page_desc_s;

  logic        hit;
  logic [31:0] hit_pa;
  logic [1:0]  hit_size;
  logic [3:0]  hit_domain;
  logic [1:0]  hit_perm;
  logic        pfault;
  logic [3:0]  pcode;
  logic        fill;
  logic [1:0]  fill_size;
  logic [19:0] fill_pa;
  logic [3:0]  fill_domain;
  logic [7:0]  fill_perm;
  logic        flush_all;
  logic        flush_one;
  logic        mmu_on;
  sect_desc_s  sect_desc;
  ptr_desc_s   ptr_desc;
  ptr_desc_s   held_ptr;
  page_desc_s  page_desc;

  assign mmu_on    = state_ff.ctrl[CTRL_EN_BIT];
  assign flush_all = REG_WR && REG_ADDR == REG_FLUSH;
  assign flush_one = REG_WR && REG_ADDR == REG_FLUSH1;
  assign sect_desc = MEM_DATA;
  assign ptr_desc  = MEM_DATA;
  assign held_ptr  = state_ff.desc1;
  assign page_desc = MEM_DATA;

  tlb_store u_tlb (
    .SYS_CLK     (SYS_CLK),
    .RST_N       (RST_N),
    .look_va     (state_ff.va),
    .fill        (fill),
    .fill_va     (state_ff.va),
    .fill_size   (fill_size),
    .fill_pa     (fill_pa),
    .fill_domain (fill_domain),
    .fill_perm   (fill_perm),
    .flush_all   (flush_all),
    .flush_one   (flush_one),
    .flush_va    (REG_WDATA),
    .hit         (hit),
    .hit_pa      (hit_pa),
    .hit_size    (hit_size),
    .hit_domain  (hit_domain),
    .hit_perm    (hit_perm)
  );

  perm_check u_perm (
    .domain_ctl (state_ff.domain_ctl),
    .domain     (hit_domain),
    .perm       (hit_perm),
    .is_section (hit_size == SZ_SECTION),
    .priv       (state_ff.priv),
    .write      (state_ff.wr),
    .sys_bit    (state_ff.ctrl[CTRL_SYS_BIT]),
    .rom_bit    (state_ff.ctrl[CTRL_ROM_BIT]),
    .fault      (pfault),
    .fault_code (pcode)
  );

  // Fill data decoded from the fetched descriptors
  always_comb begin
    fill        = 1'b0;
    fill_size   = SZ_SMALL;
    fill_pa     = page_desc.base;
    fill_domain = held_ptr.domain;
    fill_perm   = page_desc.perm;
    if (state_ff.st == L1_WAIT && MEM_ACK && sect_desc.kind == L1_SECTION) begin
      fill        = 1'b1;
      fill_size   = SZ_SECTION;
      fill_pa     = {sect_desc.base, 8'h00};
      fill_domain = sect_desc.domain;
      fill_perm   = {6'h00, sect_desc.perm};
    end else if (state_ff.st == L2_WAIT && MEM_ACK &&
                 (page_desc.kind == L2_LARGE || page_desc.kind == L2_SMALL)) begin
      fill      = 1'b1;
      fill_size = page_desc.kind == L2_LARGE ? SZ_LARGE : SZ_SMALL;
    end
  end

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.done   = 1'b0;
    nxt_state.abort  = 1'b0;
    nxt_state.rdata  = 32'h0;
    if (REG_WR) begin
      case (REG_ADDR)
        REG_CTRL:   nxt_state.ctrl       = REG_WDATA[10:0];
        REG_TBASE:  nxt_state.tbase      = REG_WDATA[31:14];
        REG_DOMAIN: nxt_state.domain_ctl = REG_WDATA;
        default:    nxt_state.ctrl       = state_ff.ctrl;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        REG_CTRL:    nxt_state.rdata = {21'h0, state_ff.ctrl};
        REG_TBASE:   nxt_state.rdata = {state_ff.tbase, 14'h0};
        REG_DOMAIN:  nxt_state.rdata = state_ff.domain_ctl;
        REG_FSTATUS: nxt_state.rdata = {24'h0, state_ff.fs_dom, state_ff.fs_code};
        REG_FADDR:   nxt_state.rdata = state_ff.fault_va;
        default:     nxt_state.rdata = 32'h0;
      endcase
    end
    case (state_ff.st)
      IDLE: begin
        if (REQ) begin
          nxt_state.va     = VA;
          nxt_state.wr     = WRITE;
          nxt_state.priv   = PRIV;
          nxt_state.ifetch = IFETCH;
          if (!mmu_on) begin
            nxt_state.done = 1'b1;
            nxt_state.pa   = VA;
          end else begin
            nxt_state.st = LOOK;
          end
        end
      end
      LOOK: begin
        if (hit) begin
          nxt_state.st   = IDLE;
          nxt_state.done = 1'b1;
          if (pfault) begin
            nxt_state.abort = 1'b1;
            nxt_state.pa    = 32'h0;
            if (!state_ff.ifetch) begin
              nxt_state.fs_code  = pcode;
              nxt_state.fs_dom   = hit_domain;
              nxt_state.fault_va = state_ff.va;
            end
          end else begin
            nxt_state.pa = hit_pa;
          end
        end else begin
          nxt_state.st       = L1_WAIT;
          nxt_state.mem_rd   = 1'b1;
          nxt_state.mem_addr = {state_ff.tbase, state_ff.va[31:20], 2'b00};
        end
      end
      L1_WAIT: begin
        if (MEM_ACK) begin
          nxt_state.mem_rd = 1'b0;
          nxt_state.desc1  = MEM_DATA;
          case (sect_desc.kind)
            L1_SECTION: nxt_state.st = FILL;
            L1_COARSE: begin
              nxt_state.st       = L2_WAIT;
              nxt_state.mem_rd   = 1'b1;
              nxt_state.mem_addr = {ptr_desc.base, state_ff.va[19:12], 2'b00};
            end
            default: begin
              nxt_state.st    = IDLE;
              nxt_state.done  = 1'b1;
              nxt_state.abort = 1'b1;
              nxt_state.pa    = 32'h0;
              if (!state_ff.ifetch) begin
                nxt_state.fs_code  = FS_TRANS_SEC;
                nxt_state.fs_dom   = 4'h0;
                nxt_state.fault_va = state_ff.va;
              end
            end
          endcase
        end
      end
      L2_WAIT: begin
        if (MEM_ACK) begin
          nxt_state.mem_rd = 1'b0;
          if (fill) begin
            nxt_state.st = FILL;
          end else begin
            nxt_state.st    = IDLE;
            nxt_state.done  = 1'b1;
            nxt_state.abort = 1'b1;
            nxt_state.pa    = 32'h0;
            if (!state_ff.ifetch) begin
              nxt_state.fs_code  = FS_TRANS_PAGE;
              nxt_state.fs_dom   = held_ptr.domain;
              nxt_state.fault_va = state_ff.va;
            end
          end
        end
      end
      FILL: begin
        // Entry is installed; rerun lookup for the permission check
        nxt_state.st = LOOK;
      end
      default: nxt_state.st = IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff    <= '0;
      state_ff.st <= IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign DONE      = state_ff.done;
  assign ABORT     = state_ff.abort;
  assign PA        = state_ff.pa;
  assign MEM_RD    = state_ff.mem_rd;
  assign MEM_ADDR  = state_ff.mem_addr;
  assign REG_RDATA = state_ff.rdata;
endmodule // mmu_top

// >>> hdl/perm_check.sv
`timescale 1ns/100ps
// Combinational domain and access-permission check
module perm_check
  import mmu_pkg::*;
(
  input  wire logic [31:0] domain_ctl,
  input  wire logic [3:0]  domain,
  input  wire logic [1:0]  perm,
  input  wire logic        is_section,
  input  wire logic        priv,
  input  wire logic        write,
  input  wire logic        sys_bit,
  input  wire logic        rom_bit,
  output logic             fault,
  output logic [3:0]       fault_code
);
  logic [1:0] dom_val;
  logic       perm_ok;

  always_comb begin
    dom_val = domain_ctl[{domain, 1'b0} +: 2];
    case (perm)
      AP_SYS:     perm_ok = !write && ((sys_bit && priv) || rom_bit);
      2'h1:       perm_ok = priv;
      AP_USER_RO: perm_ok = priv || !write;
      default:    perm_ok = 1'b1;
    endcase
    fault      = 1'b0;
    fault_code = 4'h0;
    if (dom_val == DOM_NONE || dom_val == 2'h2) begin
      fault      = 1'b1;
      fault_code = is_section ? FS_DOM_SEC : FS_DOM_PAGE;
    end else if (dom_val == DOM_CLIENT && !perm_ok) begin
      fault      = 1'b1;
      fault_code = is_section ? FS_PERM_SEC : FS_PERM_PAGE;
    end
  end
endmodule // perm_check

// >>> hdl/tlb_store.sv
`timescale 1ns/100ps
// Fully associative translation buffer, round-robin replacement
module tlb_store
  import mmu_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic [31:0] look_va,
  input  wire logic        fill,
  input  wire logic [31:0] fill_va,
  input  wire logic [1:0]  fill_size,
  input  wire logic [19:0] fill_pa,
  input  wire logic [3:0]  fill_domain,
  input  wire logic [7:0]  fill_perm,
  input  wire logic        flush_all,
  input  wire logic        flush_one,
  input  wire logic [31:0] flush_va,
  output logic             hit,
  output logic [31:0]      hit_pa,
  output logic [1:0]       hit_size,
  output logic [3:0]       hit_domain,
  output logic [1:0]       hit_perm
);
  typedef struct packed {
    logic        valid;
    logic [1:0]  size;
    logic [19:0] vtag;
    logic [19:0] pa;
    logic [3:0]  domain;
    logic [7:0]  perm;
  } entry_s;

  typedef struct packed {
    entry_s [TLB_DEPTH-1:0] ent;
    logic [IDX_W-1:0]       victim;
  } state_s;

  state_s state_ff, nxt_state;
  logic [TLB_DEPTH-1:0] match;
  logic [TLB_DEPTH-1:0] fmatch;

  function automatic logic covers(entry_s e, logic [31:0] va);
    case (e.size)
      SZ_SECTION: covers = e.vtag[19:8] == va[31:20];
      SZ_LARGE:   covers = e.vtag[19:4] == va[31:16];
      default:    covers = e.vtag == va[31:12];
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < TLB_DEPTH; g++) begin : g_cmp
      assign match[g]  = state_ff.ent[g].valid && covers(state_ff.ent[g], look_va);
      assign fmatch[g] = state_ff.ent[g].valid && covers(state_ff.ent[g], flush_va);
    end
  endgenerate

  always_comb begin
    entry_s e;
    e          = '0;
    hit        = |match;
    for (int i = 0; i < TLB_DEPTH; i++) begin
      if (match[i]) begin
        e = state_ff.ent[i];
      end
    end
    hit_size   = e.size;
    hit_domain = e.domain;
    // Sub-page permission: 1kB in small pages, 16kB in large pages
    case (e.size)
      SZ_SECTION: begin
        hit_perm = e.perm[1:0];
        hit_pa   = {e.pa[19:8], look_va[19:0]};
      end
      SZ_LARGE: begin
        hit_perm = e.perm[{look_va[15:14], 1'b0} +: 2];
        hit_pa   = {e.pa[19:4], look_va[15:0]};
      end
      default: begin
        hit_perm = e.perm[{look_va[11:10], 1'b0} +: 2];
        hit_pa   = {e.pa, look_va[11:0]};
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    if (flush_all) begin
      for (int i = 0; i < TLB_DEPTH; i++) begin
        nxt_state.ent[i].valid = 1'b0;
      end
    end else if (flush_one) begin
      for (int i = 0; i < TLB_DEPTH; i++) begin
        if (fmatch[i]) begin
          nxt_state.ent[i].valid = 1'b0;
        end
      end
    end else if (fill) begin
      // One entry per section or large page
      nxt_state.ent[state_ff.victim] = '{1'b1, fill_size, fill_va[31:12], fill_pa, fill_domain, fill_perm};
      nxt_state.victim               = state_ff.victim + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule // tlb_store

// >>> inc/mmu_pkg.sv
package mmu_pkg;
  localparam int TLB_DEPTH = 8;
  localparam int IDX_W     = 3;

  // Descriptor type encodings
  localparam logic [1:0] DESC_FAULT   = 2'h0;
  localparam logic [1:0] L1_COARSE    = 2'h1;
  localparam logic [1:0] L1_SECTION   = 2'h2;
  localparam logic [1:0] L2_LARGE     = 2'h1;
  localparam logic [1:0] L2_SMALL     = 2'h2;

  // Domain access values
  localparam logic [1:0] DOM_NONE     = 2'h0;
  localparam logic [1:0] DOM_CLIENT   = 2'h1;
  localparam logic [1:0] DOM_MANAGER  = 2'h3;

  // Access permission values
  localparam logic [1:0] AP_SYS       = 2'h0;
  localparam logic [1:0] AP_USER_RO   = 2'h2;

  // Fault status codes
  localparam logic [3:0] FS_TRANS_SEC  = 4'h5;
  localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
  localparam logic [3:0] FS_DOM_SEC    = 4'h9;
  localparam logic [3:0] FS_DOM_PAGE   = 4'hb;
  localparam logic [3:0] FS_PERM_SEC   = 4'hd;
  localparam logic [3:0] FS_PERM_PAGE  = 4'hf;

  // Page size kinds held in a buffer entry
  localparam logic [1:0] SZ_SECTION   = 2'h0;
  localparam logic [1:0] SZ_LARGE     = 2'h1;
  localparam logic [1:0] SZ_SMALL     = 2'h2;

  // Register map of the plain register port
  localparam logic [3:0] REG_CTRL     = 4'h1;
  localparam logic [3:0] REG_TBASE    = 4'h2;
  localparam logic [3:0] REG_DOMAIN   = 4'h3;
  localparam logic [3:0] REG_FSTATUS  = 4'h5;
  localparam logic [3:0] REG_FADDR    = 4'h6;
  localparam logic [3:0] REG_FLUSH    = 4'h7;
  localparam logic [3:0] REG_FLUSH1   = 4'h8;

  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_SYS_BIT = 8;
  localparam int CTRL_ROM_BIT = 9;
endpackage
